/* verilog/link_eq_regs_pkg.sv */
// Package: register map, field positions and reset values of the link and equalizer registers
// Assumes: an 8-bit register port with a byte-wide address
package link_eq_regs_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] LINK_ERR_OFS   = 8'h41;
    localparam logic [7:0] FAST_CC_OFS    = 8'h43;
    localparam logic [7:0] EQ_MANUAL_OFS  = 8'h44;
    localparam logic [7:0] EQ_FLOOR_OFS   = 8'h45;
    localparam logic [7:0] PORT_SEL_OFS   = 8'h46;
    localparam logic [7:0] LINK_STAT_OFS  = 8'h47;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h48;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h4A;

    // ==========================================================
    // Field positions
    localparam int ERR_EN_BIT      = 4;
    localparam int MISO_MODE_BIT   = 4;
    localparam int SCK_POL_BIT     = 3;
    localparam int EQ_BYPASS_BIT   = 0;
    localparam int FLOOR_EN_BIT    = 1;
    localparam int IRQ_LOCK_LOST   = 0;
    localparam int IRQ_LOCK_GAINED = 1;
    localparam int IRQ_LINK_ERR    = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] LINK_ERR_RST   = 8'h03;
    localparam logic [7:0] FAST_CC_RST    = 8'h00;
    localparam logic [7:0] EQ_MANUAL_RST  = 8'h60;
    localparam logic [7:0] EQ_FLOOR_RST   = 8'h80;

    // ==========================================================
    // Control channel modes
    typedef enum logic [2:0] {
        CC_FRAME_GPIO = 3'h0,
        CC_HS_GPIO1   = 3'h1,
        CC_HS_GPIO2   = 3'h2,
        CC_HS_GPIO4   = 3'h3,
        CC_RSVD4      = 3'h4,
        CC_RSVD5      = 3'h5,
        CC_FWD_SPI    = 3'h6,
        CC_REV_SPI    = 3'h7
    } cc_mode_t;

endpackage

/* verilog/link_ctrl_channel_eq_regs.sv */
// Link error counting, fast control channel setup, and per-port equalizer settings
// Assumes: one clock (the pixel clock), error strobes and lock are synchronous to it
//
// Operation
// - Count link errors only while the count-enable bit 4 is one.
// - Threshold field bits 3:0 resets to 3; counter runs on the pixel clock.
// - Both clock channels and control payload channel monitored; lock drops at threshold.
// - With counting disabled, the first link error drops lock.
// - Reverse SPI: data out always driven if bit 4 low, else only while selected.
// - Polarity 0 drives on falling, samples rising; polarity 1 the reverse.
// - Decode three-bit control channel mode; codes 100 and 101 reserved.
// - Bypass bit 0 set disables adaptive equalization, clear runs it.
// - Manual six-bit setting is bits 7:5 above bits 3:1 of bypass register.
// - Second port select steers equalizer register writes to the second port.
// - Floor enabled by strap or register starts adaptation from floor bits 3:0.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module link_ctrl_channel_eq_regs #(
    parameter int NUM_PORTS = 2
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire logic [7:0]           i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    output logic                      o_irq,
    input  wire logic                 i_err_clk0,
    input  wire logic                 i_err_clk1,
    input  wire logic                 i_err_payload,
    input  wire logic                 i_lock_acquire,
    output logic                      o_lock,
    input  wire logic                 i_spi_ss_n,
    output logic                      o_spi_miso_oe_n,
    output logic                      o_sck_polarity_select,
    output logic      [2:0]           o_fast_ctrl_channel_mode,
    output logic                      o_mode_rsvd,
    output logic                      o_hs_gpio,
    output logic      [2:0]           o_hs_gpio_count,
    output logic                      o_fwd_spi,
    output logic                      o_rev_spi,
    input  wire logic                 i_floor_strap,
    output logic      [NUM_PORTS-1:0] o_adapt_en,
    output logic      [NUM_PORTS*6-1:0] o_eq_manual,
    output logic      [NUM_PORTS-1:0] o_floor_en,
    output logic      [NUM_PORTS*4-1:0] o_eq_floor
);

    // ==========================================================
    // Register storage
    logic [7:0] link_err_q;
    logic [7:0] fast_cc_q;
    logic [7:0] eq_man_q   [NUM_PORTS];
    logic [7:0] eq_floor_q [NUM_PORTS];
    logic       port_sel_q;
    logic [1:0] floor_reg_q;
    logic [3:0] err_cnt_q;
    logic [3:0] err_cnt_d;
    logic       lock_q;
    logic       lock_d;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_ev;

    // ==========================================================
    // Address decode
    wire        wr_link  = i_ce && i_wr && (i_addr == link_eq_regs_pkg::LINK_ERR_OFS);
    wire        wr_cc    = i_ce && i_wr && (i_addr == link_eq_regs_pkg::FAST_CC_OFS);
    wire        wr_man   = i_ce && i_wr && (i_addr == link_eq_regs_pkg::EQ_MANUAL_OFS);
    wire        wr_flr   = i_ce && i_wr && (i_addr == link_eq_regs_pkg::EQ_FLOOR_OFS);
    wire        wr_psel  = i_ce && i_wr && (i_addr == link_eq_regs_pkg::PORT_SEL_OFS);
    wire        wr_istat = i_ce && i_wr && (i_addr == link_eq_regs_pkg::IRQ_STAT_OFS);
    wire        wr_imask = i_ce && i_wr && (i_addr == link_eq_regs_pkg::IRQ_MASK_OFS);
    wire        port_idx = port_sel_q;
    wire [7:0]  rd_mux   =
        (i_addr == link_eq_regs_pkg::LINK_ERR_OFS)  ? link_err_q :
        (i_addr == link_eq_regs_pkg::FAST_CC_OFS)   ? fast_cc_q :
        (i_addr == link_eq_regs_pkg::EQ_MANUAL_OFS) ? eq_man_q[port_idx] :
        (i_addr == link_eq_regs_pkg::EQ_FLOOR_OFS)  ? eq_floor_q[port_idx] :
        (i_addr == link_eq_regs_pkg::PORT_SEL_OFS)  ? {5'h00, floor_reg_q, port_sel_q} :
        (i_addr == link_eq_regs_pkg::LINK_STAT_OFS) ? {3'h0, lock_q, err_cnt_q} :
        (i_addr == link_eq_regs_pkg::IRQ_STAT_OFS)  ? {5'h00, irq_stat_q} :
        (i_addr == link_eq_regs_pkg::IRQ_MASK_OFS)  ? {5'h00, irq_mask_q} : 8'h00;

    // ==========================================================
    // Error counting and lock
    // three monitored channels
    wire        any_err   = i_err_clk0 | i_err_clk1 | i_err_payload;
    wire        cnt_en    = link_err_q[link_eq_regs_pkg::ERR_EN_BIT];
    wire [3:0]  threshold = link_err_q[3:0];
    wire [3:0]  cnt_inc   = err_cnt_q + 4'h1;
    // threshold compare; zero threshold treated like one
    wire        cnt_trip  = cnt_en && any_err && (cnt_inc >= threshold);
    wire        drop      = lock_q && any_err && (!cnt_en || cnt_trip);
    wire        gain      = !lock_q && i_lock_acquire;

    always_comb begin
        err_cnt_d = err_cnt_q;
        lock_d    = lock_q;
        if (gain) begin
            err_cnt_d = 4'h0;
            lock_d    = 1'b1;
        end else if (drop) begin
            lock_d    = 1'b0;
            if (cnt_en) begin
                err_cnt_d = cnt_inc;
            end
        end else if (lock_q && any_err && cnt_en && cnt_inc != 4'h0) begin
            err_cnt_d = cnt_inc;
        end
    end

    assign irq_ev = {lock_q && any_err, gain, drop};

    // ==========================================================
    // Clocked state
    // threshold reset and pixel clock counter
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            link_err_q  <= link_eq_regs_pkg::LINK_ERR_RST;
            fast_cc_q   <= link_eq_regs_pkg::FAST_CC_RST;
            port_sel_q  <= 1'b0;
            floor_reg_q <= 2'h0;
            err_cnt_q   <= 4'h0;
            lock_q      <= 1'b0;
            irq_stat_q  <= 3'h0;
            irq_mask_q  <= 3'h0;
            o_rdata     <= 8'h00;
            o_irq       <= 1'b0;
        end else if (i_ce) begin
            if (wr_link) link_err_q <= i_wdata;
            if (wr_cc) fast_cc_q <= i_wdata;
            if (wr_psel) begin
                port_sel_q  <= i_wdata[0];
                floor_reg_q <= i_wdata[2:1];
            end
            if (wr_imask) irq_mask_q <= i_wdata[2:0];
            // Set wins over write-one clear
            irq_stat_q <= (irq_stat_q & ~(wr_istat ? i_wdata[2:0] : 3'h0)) | irq_ev;
            err_cnt_q  <= err_cnt_d;
            lock_q     <= lock_d;
            o_rdata    <= i_rd ? rd_mux : 8'h00;
            o_irq      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ==========================================================
    // Per-port equalizer registers
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        wire sel = (port_idx == 1'(p));
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                eq_man_q[p]   <= link_eq_regs_pkg::EQ_MANUAL_RST;
                eq_floor_q[p] <= link_eq_regs_pkg::EQ_FLOOR_RST;
                o_adapt_en[p] <= !link_eq_regs_pkg::EQ_MANUAL_RST[link_eq_regs_pkg::EQ_BYPASS_BIT];
                o_eq_manual[p*6 +: 6] <= {link_eq_regs_pkg::EQ_MANUAL_RST[7:5],
                                          link_eq_regs_pkg::EQ_MANUAL_RST[3:1]};
                o_floor_en[p] <= 1'b0;
                o_eq_floor[p*4 +: 4] <= link_eq_regs_pkg::EQ_FLOOR_RST[3:0];
            end else if (i_ce) begin
                if (wr_man && sel) eq_man_q[p] <= i_wdata;
                if (wr_flr && sel) eq_floor_q[p] <= i_wdata;
                o_adapt_en[p] <= !eq_man_q[p][link_eq_regs_pkg::EQ_BYPASS_BIT];
                o_eq_manual[p*6 +: 6] <= {eq_man_q[p][7:5], eq_man_q[p][3:1]};
                o_floor_en[p] <= i_floor_strap | floor_reg_q[p];
                o_eq_floor[p*4 +: 4] <= eq_floor_q[p][3:0];
            end
        end
    end

    // ==========================================================
    // Control channel mode decode
    wire [2:0] mode = fast_cc_q[2:0];
    wire       miso_off = (mode == link_eq_regs_pkg::CC_REV_SPI) &&
                          fast_cc_q[link_eq_regs_pkg::MISO_MODE_BIT] && i_spi_ss_n;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_fast_ctrl_channel_mode <= 3'h0;
            o_mode_rsvd              <= 1'b0;
            o_hs_gpio                <= 1'b0;
            o_hs_gpio_count          <= 3'h0;
            o_fwd_spi                <= 1'b0;
            o_rev_spi                <= 1'b0;
            o_spi_miso_oe_n          <= 1'b0;
            o_sck_polarity_select    <= 1'b0;
            o_lock                   <= 1'b0;
        end else if (i_ce) begin
            o_fast_ctrl_channel_mode <= mode;
            o_mode_rsvd <= (mode == link_eq_regs_pkg::CC_RSVD4) ||
                           (mode == link_eq_regs_pkg::CC_RSVD5);
            o_hs_gpio   <= (mode != 3'h0) && !mode[2];
            o_hs_gpio_count <= (mode == link_eq_regs_pkg::CC_HS_GPIO1) ? 3'h1 :
                               (mode == link_eq_regs_pkg::CC_HS_GPIO2) ? 3'h2 :
                               (mode == link_eq_regs_pkg::CC_HS_GPIO4) ? 3'h4 : 3'h0;
            o_fwd_spi   <= (mode == link_eq_regs_pkg::CC_FWD_SPI);
            o_rev_spi   <= (mode == link_eq_regs_pkg::CC_REV_SPI);
            o_spi_miso_oe_n <= miso_off;
            o_sck_polarity_select <= fast_cc_q[link_eq_regs_pkg::SCK_POL_BIT];
            o_lock      <= lock_d;
        end
    end

    // ==========================================================
    // Checks
    a_lock_drop_nocnt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && lock_q && any_err && !cnt_en && !gain |=> !lock_q)
        else $error("lock kept after error with counting off");
    a_cnt_hold_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && !cnt_en && lock_q |=> err_cnt_q == $past(err_cnt_q))
        else $error("counter moved while disabled");
    a_cnt_clear_lock: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && gain |=> err_cnt_q == 4'h0 && lock_q)
        else $error("counter not cleared on lock");
    a_miso_tristate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && !fast_cc_q[4] |=> !o_spi_miso_oe_n)
        else $error("data out released in always-drive mode");
    a_eq_bypass_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_adapt_en[0] == !$past(eq_man_q[0][0]))
        else $error("adaptation enable wrong");
    a_eq_manual_val: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_eq_manual[5:0] == {$past(eq_man_q[0][7:5]), $past(eq_man_q[0][3:1])})
        else $error("manual setting wrong");
    a_port_steer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_man && port_sel_q |=> eq_man_q[0] == $past(eq_man_q[0]))
        else $error("first port written while second selected");
    a_mode_rev_spi: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && mode == 3'h7 |=> o_rev_spi && !o_hs_gpio)
        else $error("reverse spi decode wrong");
    a_polarity_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_sck_polarity_select == $past(fast_cc_q[3]))
        else $error("polarity output wrong");
    a_floor_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_eq_floor[3:0] == $past(eq_floor_q[0][3:0]))
        else $error("floor value wrong");
    a_thresh_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && cnt_trip && lock_q && !gain |=> !lock_q)
        else $error("lock kept at threshold");

    // Multi-step lock behaviour, then floor, mode decode and second-port checks
    sequence s_locked_clear;
        ##1 (lock_q && o_lock && err_cnt_q == 4'h0);
    endsequence
    sequence s_unlocked_flag;
        ##1 (!lock_q && !o_lock && irq_stat_q[link_eq_regs_pkg::IRQ_LOCK_LOST]);
    endsequence
    sequence s_counted_err;
        i_ce && lock_q && any_err && cnt_en && !cnt_trip && err_cnt_q != 4'hF;
    endsequence

    a_gain_locks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && gain |-> s_locked_clear)
        else $error("lock gain did not clear counter");
    a_drop_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && drop |-> s_unlocked_flag)
        else $error("lock drop not flagged");
    a_cnt_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_counted_err |=> err_cnt_q == $past(err_cnt_q) + 4'h1 && lock_q)
        else $error("counter did not step below threshold");
    a_floor_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_floor_en[0] == ($past(i_floor_strap) || $past(floor_reg_q[0])))
        else $error("floor enable wrong");
    a_floor_second: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_eq_floor[7:4] == $past(eq_floor_q[1][3:0]))
        else $error("second port floor wrong");
    a_mode_rsvd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && (mode == 3'h4 || mode == 3'h5) |=>
        o_mode_rsvd && !o_hs_gpio && !o_fwd_spi && !o_rev_spi)
        else $error("reserved mode decode wrong");
    a_mode_hs_four: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && mode == 3'h3 |=> o_hs_gpio && o_hs_gpio_count == 3'h4)
        else $error("four gpio decode wrong");
    a_mode_fwd_spi: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && mode == 3'h6 |=> o_fwd_spi && !o_rev_spi && !o_mode_rsvd)
        else $error("forward spi decode wrong");
    a_mode_frame: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && mode == 3'h0 |=> !o_hs_gpio && o_hs_gpio_count == 3'h0 && !o_fwd_spi && !o_rev_spi)
        else $error("frame gpio decode wrong");
    a_miso_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && mode == 3'h7 && fast_cc_q[link_eq_regs_pkg::MISO_MODE_BIT] |=>
        o_spi_miso_oe_n == $past(i_spi_ss_n))
        else $error("data out enable not following select");
    a_port_second: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_man && port_sel_q |=> eq_man_q[1] == $past(i_wdata))
        else $error("second port not written");
    a_bypass_second: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_adapt_en[1] == !$past(eq_man_q[1][0]))
        else $error("second port adaptation enable wrong");
    a_manual_second: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce |=> o_eq_manual[11:6] == {$past(eq_man_q[1][7:5]), $past(eq_man_q[1][3:1])})
        else $error("second port manual setting wrong");

endmodule

`default_nettype wire

/* tb/far_serializer_model.sv */
// Far-end serializer stand-in: channel error pulses and lock requests
// Assumes: commands come from the bench just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module far_serializer_model (
    input  wire logic       i_clk,
    input  wire logic       i_fire,
    input  wire logic [1:0] i_sel,
    output logic            o_err_clk0,
    output logic            o_err_clk1,
    output logic            o_err_payload,
    output logic            o_lock_acquire
);
    // ==========================================================
    // Link events
    // one-cycle error per channel
    // Lock request is a pulse so a dropped lock is not regained at once
    always_ff @(posedge i_clk) begin
        o_err_clk0     <= i_fire && (i_sel == 2'h0);
        o_err_clk1     <= i_fire && (i_sel == 2'h1);
        o_err_payload  <= i_fire && (i_sel == 2'h2);
        o_lock_acquire <= i_fire && (i_sel == 2'h3);
    end
endmodule
`default_nettype wire

/* tb/link_ctrl_channel_eq_regs_bench.sv */
// Bench: register bank, link lock, control channel and equalizer checks
// Assumes: one clock, clock enable held high, reads answered next cycle
`timescale 1ns/1ns
`default_nettype none
module link_ctrl_channel_eq_regs_bench;
    // ==========================================================
    // Signals
    logic        i_ref_clk     = 1'b0;
    logic        i_rst_n       = 1'b0;
    logic [7:0]  i_addr        = 8'h00;
    logic [7:0]  i_wdata       = 8'h00;
    logic        i_wr          = 1'b0;
    logic        i_rd          = 1'b0;
    logic        i_spi_ss_n    = 1'b1;
    logic        i_floor_strap = 1'b0;
    logic        fire          = 1'b0;
    logic [1:0]  sel           = 2'h0;
    logic        rd_seen       = 1'b0;
    logic        i_err_clk0, i_err_clk1, i_err_payload, i_lock_acquire;
    logic [7:0]  o_rdata;
    logic        o_irq, o_lock, o_spi_miso_oe_n, o_sck_polarity_select;
    logic        o_mode_rsvd, o_hs_gpio, o_fwd_spi, o_rev_spi;
    logic [2:0]  o_fast_ctrl_channel_mode, o_hs_gpio_count;
    logic [1:0]  o_adapt_en, o_floor_en;
    logic [11:0] o_eq_manual;
    logic [7:0]  o_eq_floor;
    logic [7:0]  exp_q[$];
    logic [7:0]  d, f;
    logic        pol;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          seed;

    link_ctrl_channel_eq_regs #(.NUM_PORTS(2)) u_dut (
        .i_ref_clk, .i_rst_n, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_irq, .i_err_clk0, .i_err_clk1, .i_err_payload, .i_lock_acquire, .o_lock,
        .i_spi_ss_n, .o_spi_miso_oe_n, .o_sck_polarity_select, .o_fast_ctrl_channel_mode,
        .o_mode_rsvd, .o_hs_gpio, .o_hs_gpio_count, .o_fwd_spi, .o_rev_spi, .i_floor_strap,
        .o_adapt_en, .o_eq_manual, .o_floor_en, .o_eq_floor
    );
    far_serializer_model u_far (
        .i_clk(i_ref_clk), .i_fire(fire), .i_sel(sel), .o_err_clk0(i_err_clk0),
        .o_err_clk1(i_err_clk1), .o_err_payload(i_err_payload),
        .o_lock_acquire(i_lock_acquire)
    );

    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic pulse(input logic [1:0] s);
        @(posedge i_ref_clk);
        fire <= 1'b1;
        sel  <= s;
        @(posedge i_ref_clk);
        fire <= 1'b0;
        settle(3);
    endtask
    task automatic end_sim();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Read monitor: oldest note against the answer cycle
    always @(posedge i_ref_clk) rd_seen <= i_rd;
    always @(negedge i_ref_clk) begin
        if (rd_seen) begin
            chk("rdata", o_rdata, exp_q.pop_front());
        end
    end

    // Hang guard, far above the roughly 120 cycles needed
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed = $urandom(32'h0000_e2a4);
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(8'h41, 8'h03);
        rd(8'h43, 8'h00);
        rd(8'h44, 8'h60);
        rd(8'h42, 8'h00);
        settle(1);
        chk("adapt_en", o_adapt_en, 2'b11);
        chk("eq_manual", o_eq_manual, {2{6'h18}});
        for (int m = 0; m < 8; m++) begin
            pol = 1'($urandom);
            wr(8'h43, {4'h0, pol, 3'(m)});
            settle(2);
            chk("mode", {o_mode_rsvd, o_hs_gpio, o_fwd_spi, o_rev_spi, o_hs_gpio_count,
                o_fast_ctrl_channel_mode}, {m == 4 || m == 5, m > 0 && m < 4, m == 6,
                m == 7, 3'(m == 3 ? 4 : (m < 3 ? m : 0)), 3'(m)});
            chk("sck_pol", o_sck_polarity_select, pol);
        end
        chk("miso_oe_n", o_spi_miso_oe_n, 1'b0);
        wr(8'h43, 8'h17);
        settle(2);
        chk("miso_oe_n", o_spi_miso_oe_n, 1'b1);
        @(posedge i_ref_clk);
        i_spi_ss_n <= 1'b0;
        settle(2);
        chk("miso_oe_n", o_spi_miso_oe_n, 1'b0);
        d = 8'($urandom) | 8'h01;
        f = 8'($urandom);
        wr(link_eq_regs_pkg::PORT_SEL_OFS, 8'h05);
        wr(8'h44, d);
        wr(8'h45, f);
        rd(8'h44, d);
        rd(8'h45, f);
        settle(2);
        chk("adapt_en", o_adapt_en, 2'b01);
        chk("eq_manual", o_eq_manual, {d[7:5], d[3:1], 6'h18});
        chk("eq_floor", o_eq_floor, {f[3:0], 4'h0});
        chk("floor_en", o_floor_en, 2'b10);
        @(posedge i_ref_clk);
        i_floor_strap <= 1'b1;
        settle(2);
        chk("floor_en", o_floor_en, 2'b11);
        wr(link_eq_regs_pkg::PORT_SEL_OFS, 8'h00);
        rd(8'h44, 8'h60);
        wr(link_eq_regs_pkg::IRQ_MASK_OFS, 8'h01);
        wr(8'h41, 8'h12);
        pulse(2'h3);
        chk("lock", o_lock, 1'b1);
        pulse(2'h0);
        rd(link_eq_regs_pkg::LINK_STAT_OFS, 8'h11);
        settle(1);
        chk("lock", o_lock, 1'b1);
        pulse(2'h2);
        chk("lock", o_lock, 1'b0);
        settle(2);
        chk("irq", o_irq, 1'b1);
        rd(link_eq_regs_pkg::IRQ_STAT_OFS, 8'h07);
        wr(link_eq_regs_pkg::IRQ_STAT_OFS, 8'h01);
        settle(2);
        chk("irq", o_irq, 1'b0);
        wr(8'h41, 8'h02);
        pulse(2'h3);
        rd(link_eq_regs_pkg::LINK_STAT_OFS, 8'h10);
        pulse(2'h1);
        chk("lock", o_lock, 1'b0);
        settle(4);
        end_sim();
    end
endmodule
`default_nettype wire
